/* File: include/sar_readout_pkg.sv */
// constants and types shared by the converter control and its result buffer
package sar_readout_pkg;

	// ----------------------------------------------------------------
	// data word
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W     = 18;
	localparam int unsigned BIT_IDX_W  = 5;
	localparam int unsigned BUF_DEPTH  = 2;
	localparam int unsigned BUF_CNT_W  = 2;

	// ----------------------------------------------------------------
	// timing: system clock and conversion time
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CONV_TIME_NS  = 460;
	// least conversion time, rounded up to whole cycles
	localparam int unsigned CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// one approximation step; rounded down so all steps fit the conversion
	localparam int unsigned STEP_CYC      = CONV_CYC / WORD_W;
	localparam int unsigned CYC_W         = 6;

	localparam logic [CYC_W-1:0]     CONV_LAST  = CYC_W'(CONV_CYC - 1);
	localparam logic [CYC_W-1:0]     STEP_LAST  = CYC_W'(STEP_CYC - 1);
	localparam logic [BIT_IDX_W-1:0] WORD_BITS  = BIT_IDX_W'(WORD_W);
	localparam logic [WORD_W-1:0]    SAR_START  = 18'h20000;
	localparam logic [WORD_W-1:0]    WORD_ZERO  = 18'h00000;

	// ----------------------------------------------------------------
	// conversion sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_NAP     = 2'b00,
		ST_CONVERT = 2'b01,
		ST_HOLD    = 2'b10
	} conv_state_t;

endpackage

/* File: include/word_stream_if.sv */
// valid/ready carrier for finished conversion words
`timescale 1ns/10ps
interface word_stream_if;
	import sar_readout_pkg::*;

	logic              valid;
	logic              ready;
	logic [WORD_W-1:0] data;

	modport source
	(
		output valid,
		output data,
		input  ready
	);

	modport sink
	(
		input  valid,
		input  data,
		output ready
	);
endinterface

/* File: rtl/result_buffer.sv */
// two-entry result buffer between the sequencer and the serial shifter
`timescale 1ns/10ps
module result_buffer
	import sar_readout_pkg::*;
(
	input  wire logic      mclk_i,
	input  wire logic      reset_i,
	word_stream_if.sink    fill_s,
	word_stream_if.source  drain_s
);

	logic [WORD_W-1:0]    mem_q [BUF_DEPTH];
	logic                 wr_ptr_q;
	logic                 rd_ptr_q;
	logic [BUF_CNT_W-1:0] count_q;
	wire                  push;
	wire                  pop;

	// ----------------------------------------------------------------
	// handshake decode
	// ----------------------------------------------------------------
	// full refuses the filler, so a stalled reader stalls the sequencer
	assign fill_s.ready  = (count_q != BUF_CNT_W'(BUF_DEPTH));
	assign drain_s.valid = (count_q != '0);
	assign drain_s.data  = mem_q[rd_ptr_q];
	assign push          = fill_s.valid & fill_s.ready;
	assign pop           = drain_s.valid & drain_s.ready;

	// ----------------------------------------------------------------
	// storage and pointers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= ~wr_ptr_q;
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			count_q <= count_q + BUF_CNT_W'(push) - BUF_CNT_W'(pop);
		end
	end

	// data needs no reset; count guards every read
	always_ff @(posedge mclk_i)
	begin
		if (push)
			mem_q[wr_ptr_q] <= fill_s.data;
	end

endmodule

/* File: rtl/sar_adc_conversion_readout.sv */
// conversion sequencer and serial readout of the 18-bit approximation converter
`timescale 1ns/10ps

// Overview of operation
// RULE1: a rising convert_start edge wakes the block and starts a conversion.
// RULE2: busy rises as conversion begins and falls once it completes; here busy stays high while the result buffer is full.
// RULE3: cascade-select low: shared pin is an active-low output enable.
// RULE4: cascade-select high: shared pin is serial data from an upstream converter.
// RULE5: enabled output shifts one bit per shift-clock rising edge, MSB first.
// RULE6: each result is an 18-bit word spanning 2^18 levels.
// RULE7: results are two's complement; negative inputs set the top bit.
// RULE8: acquisition between conversions; conversion begins on convert_start rise.
// RULE9: eighteen binary-weighted approximation steps, half reference down to one LSB.
// RULE10: internal timer sets conversion length; host only waits for busy.
// RULE11: after each conversion the block naps until the next start edge; here it naps only once the result buffer accepts the word.
// RULE12: result readable right after the same conversion, no pipeline delay; here a result waits while an earlier word is unread.
// RULE13: host keeps the shift clock at or below 100 MHz.
// RULE14: normal mode drives output only while enable is low, else releases.
// RULE15: chain mode sends own 18 bits, then forwards upstream bits in order.
// RULE16: host keeps shift clock idle while busy, reads after busy falls.
module sar_adc_conversion_readout
	import sar_readout_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              reset_i,
	input  wire logic              convert_start_i,
	input  wire logic              serial_clk_i,
	input  wire logic              cascade_select_i,
	input  wire logic              enable_or_cascade_in_i,
	input  wire logic              comparator_i,
	output logic                   busy_o,
	output logic                   sample_o,
	output logic                   nap_o,
	output logic [WORD_W-1:0]      capacitor_dac_o,
	output logic                   result_serial_out_o,
	output logic                   result_serial_oe_o
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic cnv_s1_q;
	logic cnv_s2_q;
	logic cnv_prev_q;
	logic sclk_s1_q;
	logic sclk_s2_q;
	logic sclk_prev_q;
	logic shared_s1_q;
	logic shared_s2_q;
	logic chain_s1_q;
	logic chain_s2_q;

	// pins and the slow shift clock are sampled twice before use
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			cnv_s1_q    <= 1'b0;
			cnv_s2_q    <= 1'b0;
			cnv_prev_q  <= 1'b0;
			sclk_s1_q   <= 1'b0;
			sclk_s2_q   <= 1'b0;
			sclk_prev_q <= 1'b0;
			shared_s1_q <= 1'b1;
			shared_s2_q <= 1'b1;
			chain_s1_q  <= 1'b0;
			chain_s2_q  <= 1'b0;
		end
		else
		begin
			cnv_s1_q    <= convert_start_i;
			cnv_s2_q    <= cnv_s1_q;
			cnv_prev_q  <= cnv_s2_q;
			sclk_s1_q   <= serial_clk_i;
			sclk_s2_q   <= sclk_s1_q;
			sclk_prev_q <= sclk_s2_q;
			shared_s1_q <= enable_or_cascade_in_i;
			shared_s2_q <= shared_s1_q;
			chain_s1_q  <= cascade_select_i;
			chain_s2_q  <= chain_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// edge and mode decode
	// ----------------------------------------------------------------
	wire cnv_rise  = cnv_s2_q & ~cnv_prev_q;   // RULE1
	wire sclk_rise = sclk_s2_q & ~sclk_prev_q;
	wire chain_on  = chain_s2_q;                // RULE4
	// in normal mode the shared pin is an active-low enable
	wire output_enable_n = shared_s2_q;        // RULE3
	wire cascade_data_in = shared_s2_q;        // RULE4
	wire drive_en  = chain_on | ~output_enable_n; // RULE14

	// ----------------------------------------------------------------
	// conversion sequencer registers
	// ----------------------------------------------------------------
	conv_state_t            state_q;
	conv_state_t            state_d;
	logic [CYC_W-1:0]       cyc_q;
	logic [CYC_W-1:0]       cyc_d;
	logic [CYC_W-1:0]       step_q;
	logic [CYC_W-1:0]       step_d;
	logic [BIT_IDX_W-1:0]   bit_idx_q;
	logic [BIT_IDX_W-1:0]   bit_idx_d;
	logic [WORD_W-1:0]      sar_q;
	logic [WORD_W-1:0]      sar_d;
	logic                   busy_q;
	logic                   busy_d;

	word_stream_if fill_s ();
	word_stream_if drain_s ();

	// bit under trial; index 0 is the half-reference weight
	function automatic logic [WORD_W-1:0] weight(input logic [BIT_IDX_W-1:0] idx);
		weight = SAR_START >> idx;
	endfunction

	// ----------------------------------------------------------------
	// approximation step decode
	// ----------------------------------------------------------------
	wire step_end  = (step_q == STEP_LAST) && (bit_idx_q < WORD_BITS);  // RULE9
	wire conv_last = (cyc_q == CONV_LAST);                              // RULE10
	// comparator low means the trial overshoots: drop the bit
	wire [WORD_W-1:0] sar_kept  = comparator_i ? sar_q : (sar_q & ~weight(bit_idx_q));
	wire [WORD_W-1:0] sar_next  = sar_kept | weight(bit_idx_q + BIT_IDX_W'(1));
	// core code is offset binary; flip the top bit for two's complement
	wire [WORD_W-1:0] code_twos = {~sar_q[WORD_W-1], sar_q[WORD_W-2:0]}; // RULE7

	assign fill_s.valid = ((state_q == ST_CONVERT) && conv_last) || (state_q == ST_HOLD);
	assign fill_s.data  = code_twos;                                     // RULE6

	// ----------------------------------------------------------------
	// sequencer next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d   = state_q;
		cyc_d     = cyc_q;
		step_d    = step_q;
		bit_idx_d = bit_idx_q;
		sar_d     = sar_q;
		busy_d    = busy_q;
		case (state_q)
			ST_NAP:
			begin
				// start edges are only honoured here; extra edges are ignored
				if (cnv_rise)                               // RULE8
				begin
					state_d   = ST_CONVERT;
					cyc_d     = '0;
					step_d    = '0;
					bit_idx_d = '0;
					sar_d     = SAR_START;
					busy_d    = 1'b1;                      // RULE2
				end
			end
			ST_CONVERT:
			begin
				cyc_d  = cyc_q + CYC_W'(1);
				step_d = step_end ? '0 : step_q + CYC_W'(1);
				if (step_end)
				begin
					sar_d     = (bit_idx_q == WORD_BITS - BIT_IDX_W'(1)) ? sar_kept : sar_next;
					bit_idx_d = bit_idx_q + BIT_IDX_W'(1);    // RULE9
				end
				if (conv_last)
				begin
					// a full buffer holds busy high rather than drop a word
					if (fill_s.ready)
					begin
						state_d = ST_NAP;                   // RULE11
						busy_d  = 1'b0;                     // RULE2
					end
					else
						state_d = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				if (fill_s.ready)
				begin
					state_d = ST_NAP;                       // RULE11
					busy_d  = 1'b0;
				end
			end
			default:
			begin
				state_d = ST_NAP;
				busy_d  = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			state_q   <= ST_NAP;
			cyc_q     <= '0;
			step_q    <= '0;
			bit_idx_q <= '0;
			sar_q     <= WORD_ZERO;
			busy_q    <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			cyc_q     <= cyc_d;
			step_q    <= step_d;
			bit_idx_q <= bit_idx_d;
			sar_q     <= sar_d;
			busy_q    <= busy_d;
		end
	end

	// ----------------------------------------------------------------
	// analog-facing and status outputs
	// ----------------------------------------------------------------
	logic sample_q;
	logic nap_q;
	logic [WORD_W-1:0] dac_q;

	// sampling switch closed and core napping whenever busy is low
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			sample_q <= 1'b1;
			nap_q    <= 1'b1;
			dac_q    <= WORD_ZERO;
		end
		else
		begin
			sample_q <= (state_d == ST_NAP);           // RULE8
			nap_q    <= (state_d == ST_NAP);           // RULE11
			dac_q    <= sar_d;                          // RULE9
		end
	end

	// ----------------------------------------------------------------
	// result buffer
	// ----------------------------------------------------------------
	result_buffer u_result_buffer
	(
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.fill_s  (fill_s),
		.drain_s (drain_s)
	);

	// ----------------------------------------------------------------
	// serial shifter
	// ----------------------------------------------------------------
	logic [WORD_W-1:0]    shreg_q;
	logic [WORD_W-1:0]    shreg_d;
	logic [BIT_IDX_W-1:0] shifted_q;
	logic [BIT_IDX_W-1:0] shifted_d;
	logic                 sdo_q;
	logic                 oe_q;

	// a new word loads only once the current own word has gone out,
	// so an own word still in flight is not cut short; forwarded chain bits can be
	wire own_done = (shifted_q >= WORD_BITS);
	wire load     = drain_s.valid & own_done;                  // RULE12
	// shifting is ignored while converting or while the output is off
	wire shift    = sclk_rise & drive_en & ~busy_q & ~load;  // RULE5 RULE16

	assign drain_s.ready = own_done;

	// upstream bits enter at the bottom, so they leave in arrival order
	always_comb
	begin
		shreg_d   = shreg_q;
		shifted_d = shifted_q;
		if (load)
		begin
			shreg_d   = drain_s.data;
			shifted_d = '0;
		end
		else if (shift)
		begin
			shreg_d   = {shreg_q[WORD_W-2:0], chain_on & cascade_data_in}; // RULE15
			shifted_d = own_done ? shifted_q : shifted_q + BIT_IDX_W'(1);
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			shreg_q   <= WORD_ZERO;
			shifted_q <= WORD_BITS;
			sdo_q     <= 1'b0;
			oe_q      <= 1'b0;
		end
		else
		begin
			shreg_q   <= shreg_d;
			shifted_q <= shifted_d;
			sdo_q     <= shreg_d[WORD_W-1];               // RULE5
			oe_q      <= drive_en;                          // RULE14
		end
	end

	// ----------------------------------------------------------------
	// top outputs, all from flops
	// ----------------------------------------------------------------
	assign busy_o              = busy_q;
	assign sample_o            = sample_q;
	assign nap_o               = nap_q;
	assign capacitor_dac_o     = dac_q;
	assign result_serial_out_o = sdo_q;
	assign result_serial_oe_o  = oe_q;

endmodule

/* File: test/sar_adc_conversion_readout_test.sv */
// self-checking bench for the conversion readout
`timescale 1ns/10ps
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %0t %h %h", $time, (g), (e)); end end
module sar_adc_conversion_readout_test
	import sar_readout_pkg::*;
;
	typedef struct packed { logic ch; logic [WORD_W-1:0] code; logic [WORD_W-1:0] up; } row_t;
	// expected two's complement result beside mode and upstream bits
	localparam row_t ROWS [7] = '{{1'b0, 18'h00000, 18'h00000}, {1'b0, 18'h3ffff, 18'h00000},
		{1'b0, 18'h20000, 18'h00000}, {1'b0, 18'h1ffff, 18'h00000},
		{1'b0, 18'h2a5c3, 18'h00000}, {1'b1, 18'h12345, 18'h2c0f3},
		{1'b1, 18'h3fffe, 18'h00001}};
	localparam logic [WORD_W-1:0] FILL_OB [3] = '{18'h00123, 18'h3ff00, 18'h15555};
	logic			clk, rst, chain, start, sclk, pin, busy, sample, nap, dout, oe;
	logic [WORD_W-1:0]	tgt, dac;
	logic [35:0]		got;
	wire			cmp;
	int			fail_count, check_count, cyc;
	// analog core stand-in: keep the trial bit while input is at or above it
	assign cmp = (tgt >= dac);
	sar_adc_conversion_readout i_dut (.mclk_i(clk), .reset_i(rst), .convert_start_i(start),
		.serial_clk_i(sclk), .cascade_select_i(chain), .enable_or_cascade_in_i(pin),
		.comparator_i(cmp), .busy_o(busy), .sample_o(sample), .nap_o(nap),
		.capacitor_dac_o(dac), .result_serial_out_o(dout), .result_serial_oe_o(oe));
	sar_host_model i_host (.mclk_i(clk), .busy_i(busy), .data_i(dout),
		.convert_start_o(start), .serial_clk_o(sclk), .enable_or_cascade_o(pin));
	task automatic finish_test();
		fail_count += i_host.tmo;
		if (fail_count == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			finish_test();
		end
	end
	initial
	begin
		rst = 1'b1;
		chain = 1'b0;
		tgt = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		i_host.set_pin(1'b0);
		// table rows: one conversion and one read each
		foreach (ROWS[i])
		begin
			chain <= ROWS[i].ch;
			tgt <= ROWS[i].code ^ SAR_START;
			repeat (6) @(posedge clk);
			i_host.convert();
			i_host.read_bits(ROWS[i].ch ? 36 : 18, ROWS[i].ch, ROWS[i].up, got);
			`CHECK(ROWS[i].ch ? got[35:18] : got[17:0], ROWS[i].code)
			`CHECK(got[17:0], ROWS[i].ch ? ROWS[i].up : ROWS[i].code)
		end
		chain <= 1'b0;
		i_host.set_pin(1'b0);
		// a second start inside a conversion leaves no trace
		tgt <= 18'h0f0f0;
		i_host.convert();
		i_host.convert();
		i_host.wait_low();
		repeat (10) @(posedge clk);
		`CHECK(busy, 1'b0)
		// shifts while released are ignored; word still starts at its top bit
		i_host.set_pin(1'b1);
		repeat (6) @(posedge clk);
		`CHECK(oe, 1'b0)
		i_host.read_bits(3, 1'b0, '0, got);
		i_host.set_pin(1'b0);
		repeat (6) @(posedge clk);
		`CHECK(oe, 1'b1)
		i_host.read_bits(18, 1'b0, '0, got);
		`CHECK(got[17:0], 18'h2f0f0)
		// fill shifter and buffer, drain in order, refill past full
		for (int k = 0; k < 7; k++)
		begin
			if (k == 3)
				for (int j = 0; j < 3; j++)
				begin
					i_host.read_bits(18, 1'b0, '0, got);
					`CHECK(got[17:0], FILL_OB[j] ^ SAR_START)
				end
			tgt <= FILL_OB[k % 3];
			repeat (2) @(posedge clk);
			i_host.convert();
			if (k < 6) i_host.wait_low();
		end
		// full buffer holds the conversion end instead of losing a word
		repeat (80) @(posedge clk);
		`CHECK(busy, 1'b1)
		// reset in mid-run clears the stalled conversion
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		`CHECK({busy, sample, nap, dac, dout, oe}, {3'b011, 18'h00000, 2'b00})
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		i_host.convert();
		i_host.read_bits(18, 1'b0, '0, got);
		// input still holds the last fill level; the stalled word was lost to reset
		`CHECK(got[17:0], FILL_OB[0] ^ SAR_START)
		finish_test();
	end
endmodule

/* File: test/sar_host_model.sv */
// host controller model: start pulses and shift-clock reads
`timescale 1ns/10ps
module sar_host_model
(
	input wire logic	mclk_i,
	input wire logic	busy_i,
	input wire logic	data_i,
	output logic		convert_start_o,
	output logic		serial_clk_o,
	output logic		enable_or_cascade_o
);
	int	tmo;
	initial
	begin
		convert_start_o = 1'b0;
		serial_clk_o = 1'b0;
		enable_or_cascade_o = 1'b1;
		tmo = 0;
	end
	// bounded wait for the conversion to finish
	task automatic wait_low();
		int n;
		n = 0;
		while (busy_i !== 1'b0 && n < 2000)
		begin
			@(posedge mclk_i);
			n++;
		end
		if (n >= 2000) tmo++;
	endtask
	// start pulse held long enough for the pin synchroniser
	task automatic convert();
		@(posedge mclk_i);
		convert_start_o <= 1'b1;
		repeat (5) @(posedge mclk_i);
		convert_start_o <= 1'b0;
		repeat (2) @(posedge mclk_i);
	endtask
	task automatic set_pin(input logic v);
		@(posedge mclk_i);
		enable_or_cascade_o <= v;
	endtask
	// 80 ns shift period; bit sampled just before each rise
	task automatic read_bits(input int n, input logic ch, input logic [17:0] up,
		output logic [35:0] got);
		got = '0;
		wait_low();
		for (int i = 0; i < n; i++)
		begin
			if (ch) enable_or_cascade_o <= (i < 18) ? up[17-i] : ~enable_or_cascade_o;
			repeat (4) @(posedge mclk_i);
			got = {got[34:0], data_i};
			serial_clk_o <= 1'b1;
			repeat (4) @(posedge mclk_i);
			serial_clk_o <= 1'b0;
		end
		// released line shows the inverse of its last value
		if (ch) enable_or_cascade_o <= ~enable_or_cascade_o;
	endtask
endmodule

/* File: test/sar_readout_props.sv */
// port checker for the conversion readout
`timescale 1ns/10ps
module sar_readout_props
	import sar_readout_pkg::*;
(
	input wire logic		mclk_i,
	input wire logic		reset_i,
	input wire logic		convert_start_i,
	input wire logic		serial_clk_i,
	input wire logic		cascade_select_i,
	input wire logic		enable_or_cascade_in_i,
	input wire logic		comparator_i,
	input wire logic		busy_o,
	input wire logic		sample_o,
	input wire logic		nap_o,
	input wire logic [WORD_W-1:0]	capacitor_dac_o,
	input wire logic		result_serial_out_o,
	input wire logic		result_serial_oe_o
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic [6:0]	blen_q;
	logic [7:0]	cause_q;
	// busy length so far; recent shift or busy activity explains a data change
	always_ff @(posedge mclk_i)
	begin
		blen_q <= (reset_i | ~busy_o) ? 7'h00 : blen_q + 7'h01;
		cause_q <= reset_i ? 8'h00 : {cause_q[6:0], serial_clk_i | busy_o};
	end
	default clocking dc @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_start;
		$rose(convert_start_i) && nap_o |-> ##[2:5] busy_o;
	endproperty
	a_start: assert property (p_start) else $error("start edge missed");
	property p_first;
		$rose(busy_o) |-> capacitor_dac_o == SAR_START && !sample_o;
	endproperty
	a_first: assert property (p_first) else $error("bad first trial");
	property p_len;
		$fell(busy_o) |-> blen_q >= 7'(CONV_CYC);
	endproperty
	a_len: assert property (p_len) else $error("conversion too short");
	property p_phase;
		nap_o == sample_o && sample_o == !busy_o;
	endproperty
	a_phase: assert property (p_phase) else $error("phase flags disagree");
	property p_oe_off;
		(!cascade_select_i && enable_or_cascade_in_i) [*5] |-> !result_serial_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output not released");
	property p_oe_on;
		(!cascade_select_i && !enable_or_cascade_in_i) [*5] |-> result_serial_oe_o;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not driven");
	property p_chain_oe;
		cascade_select_i [*5] |-> result_serial_oe_o;
	endproperty
	a_chain_oe: assert property (p_chain_oe) else $error("chain output off");
	property p_cause;
		$changed(result_serial_out_o) |-> |cause_q;
	endproperty
	a_cause: assert property (p_cause) else $error("data moved unclocked");
	// main scenarios
	c_conv: cover property ($fell(busy_o));
	c_chain: cover property (cascade_select_i && $rose(serial_clk_i));
	c_stall: cover property (blen_q > 7'd50);
endmodule

bind sar_adc_conversion_readout sar_readout_props i_props
(
	.mclk_i(mclk_i), .reset_i(reset_i), .convert_start_i(convert_start_i),
	.serial_clk_i(serial_clk_i), .cascade_select_i(cascade_select_i),
	.enable_or_cascade_in_i(enable_or_cascade_in_i), .comparator_i(comparator_i),
	.busy_o(busy_o), .sample_o(sample_o), .nap_o(nap_o),
	.capacitor_dac_o(capacitor_dac_o), .result_serial_out_o(result_serial_out_o),
	.result_serial_oe_o(result_serial_oe_o)
);
